//--- lcp_pkg.sv
// package: constants and types of the lin command packet handler
package lcp_pkg;
   // apb register byte addresses
   localparam logic [11:0] LCP_ADDR_CMD = 12'h000;
   localparam logic [11:0] LCP_ADDR_RSP = 12'h004;
   localparam logic [11:0] LCP_ADDR_STAT = 12'h008;
   localparam logic [11:0] LCP_ADDR_CTRL = 12'h00c;
   localparam logic [11:0] LCP_ADDR_MON = 12'h010;
   // ctrl register bits
   localparam int LCP_CTRL_CLR_OVR = 0;
   localparam int LCP_CTRL_CLR_BAD = 1;
   localparam int LCP_CTRL_ABORT = 2;
   // packet byte values
   localparam logic [7:0] LCP_LEAD = 8'h23;
   localparam logic [7:0] LCP_OWN_NODE = 8'h01;
   localparam logic [7:0] LCP_LIN_IF = 8'h04;
   localparam logic [7:0] LCP_TYPE_CMD = 8'h00;
   localparam logic [7:0] LCP_TYPE_RSP = 8'h01;
   localparam logic [7:0] LCP_TYPE_ACK = 8'h02;
   localparam logic [7:0] LCP_CMD_FRD = 8'h30;
   localparam logic [7:0] LCP_CMD_MON = 8'hf2;
   localparam logic [7:0] LCP_MODE_OUT = 8'h01;
   // packet lengths
   localparam logic [15:0] LCP_HDR_LEN = 16'h000c;
   localparam logic [15:0] LCP_FRD_LEN = 16'h001c;
   localparam logic [7:0] LCP_ACK_OK_LEN = 8'h11;
   localparam logic [7:0] LCP_ACK_ERR_LEN = 8'h12;
   localparam logic [7:0] LCP_RSP_LEN = 8'h10;
   localparam logic [15:0] LCP_BUF_LEN = 16'h001c;
   // fault codes and their one-letter texts
   localparam logic [31:0] LCP_FLT_NONE = 32'h0;
   localparam logic [31:0] LCP_FLT_ADDR = 32'h1;
   localparam logic [31:0] LCP_FLT_LEN = 32'h2;
   localparam logic [31:0] LCP_FLT_CMD = 32'h3;
   localparam logic [31:0] LCP_FLT_TYPE = 32'h4;
   localparam logic [7:0] LCP_TXT_ADDR = 8'h41;
   localparam logic [7:0] LCP_TXT_LEN = 8'h4c;
   localparam logic [7:0] LCP_TXT_CMD = 8'h43;
   localparam logic [7:0] LCP_TXT_TYPE = 8'h54;

   // parser states, gray along recv -> exec -> send
   typedef enum logic [1:0] {
      LCP_RECV = 2'b00,
      LCP_EXEC = 2'b01,
      LCP_SEND = 2'b11
   } lcp_state_t;

   // defined lin frame response handed to the lin engine
   typedef struct packed {
      logic [7:0] id;
      logic out_en;
      logic [7:0] staging_select;
      logic stage_en;
      logic [7:0] repeat_total;
      logic [3:0] dlc;
      logic [7:0][7:0] data;
   } lcp_lin_resp_t;

   // whole state of the handler
   typedef struct packed {
      lcp_state_t st;
      logic [27:0][7:0] rx;
      logic [15:0] rx_cnt;
      logic [7:0] tx_idx;
      logic [7:0] tx_len;
      logic [7:0] rsp_type;
      logic [7:0] rsp_cmd;
      logic [7:0] rsp_node;
      logic [7:0] rsp_ch;
      logic [7:0] echo_tag;
      logic [31:0] fault_code;
      logic [7:0] fault_text;
      logic [31:0] entry_total;
      logic ovr;
      logic bad;
      lcp_lin_resp_t lin;
      logic lin_def;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } lcp_regs_t;
endpackage

//--- lcp_handler.sv
// lin command packet handler: apb byte port, parser, reply builder
//
// Overview of operation
// R1 - every packet starts with byte 0x23
// R2 - flags bit0: always acknowledge the command; the code answers a good monitor read with a response (type 1), not an ack
// R3 - flags bit1: acknowledge only on error
// R4 - bytes 2,3 total length, low first
// R5 - frame definition command is 28 bytes long
// R6 - command targets node 1, interface 4
// R7 - host source node 0, channel 0
// R8 - reply swaps source and destination addressing
// R9 - echo tag byte 9 returned unchanged
// R10 - host zeroes reserved bytes
// R11 - acknowledgment repeats command code at 11
// R12 - fault code bytes 12-15, zero is success
// R13 - zero-terminated fault text follows, length 17; the code sends 18 bytes when a fault text is present
// R14 - id byte 12, mode 1 outputs response
// R15 - staging select 0 means no preparing
// R16 - byte 15 gives output repeat total
// R17 - dlc at 16, slots beyond ignored
// R18 - monitor read is header-only code 0xf2
// R19 - monitor response starts with entry total
// R20 - type byte: 0 command, 1 response, 2 ack
`timescale 1ns/10ps
module lcp_handler
   import lcp_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // lin frame response definition
   output lcp_pkg::lcp_lin_resp_t lin_resp,
   output logic lin_define
);
   import lcp_pkg::*;

   lcp_regs_t r_q; // registered state
   lcp_regs_t r_d; // next state
   logic acc; // first access cycle
   logic done; // completing edge
   logic [15:0] pkt_len; // length field of the command
   logic [15:0] cnt_nx; // byte count after this write
   logic ok; // command executed without fault
   logic [7:0] cur_byte; // reply byte at tx_idx
   logic [31:0] word; // payload word of the reply

   // payload word: entry total for responses, fault code otherwise
   always_comb begin
      if (r_q.rsp_type == LCP_TYPE_RSP) begin
         word = r_q.entry_total; // [R19]
      end else begin
         word = r_q.fault_code; // [R12]
      end
   end

   // reply byte selected by index
   always_comb begin
      case (r_q.tx_idx)
         8'h00: cur_byte = LCP_LEAD; // [R1]
         8'h01: cur_byte = 8'h00;
         8'h02: cur_byte = r_q.tx_len; // [R4]
         8'h03: cur_byte = 8'h00;
         8'h04: cur_byte = r_q.rsp_node; // [R8]
         8'h05: cur_byte = r_q.rsp_ch; // [R8]
         8'h06: cur_byte = LCP_OWN_NODE; // [R8]
         8'h07: cur_byte = LCP_LIN_IF; // [R8]
         8'h08: cur_byte = r_q.rsp_type; // [R20]
         8'h09: cur_byte = r_q.echo_tag; // [R9]
         8'h0b: cur_byte = r_q.rsp_cmd; // [R11]
         8'h0c: cur_byte = word[7:0]; // [R12]
         8'h0d: cur_byte = word[15:8];
         8'h0e: cur_byte = word[23:16];
         8'h0f: cur_byte = word[31:24];
         8'h10: cur_byte = r_q.fault_text; // [R13]
         default: cur_byte = 8'h00; // reserved and terminator
      endcase
   end

   // bus phases: one wait state, work done on the completing edge
   assign acc = psel & penable & ~r_q.pready;
   assign done = psel & penable & r_q.pready;
   assign pkt_len = {r_q.rx[3], r_q.rx[2]}; // [R4]
   assign cnt_nx = r_q.rx_cnt + 16'h0001;

   // next state
   always_comb begin
      ok = 1'b0; // set once the fault check of a command is made
      r_d = r_q;
      r_d.lin_def = 1'b0;
      r_d.pready = 1'b0;
      r_d.pslverr = 1'b0;
      r_d.prdata = 32'h0;
      // access phase: answer with data or error
      if (acc) begin
         r_d.pready = 1'b1;
         case (paddr)
            LCP_ADDR_CMD, LCP_ADDR_CTRL: ;
            LCP_ADDR_RSP: begin
               if (!pwrite && r_q.st == LCP_SEND) begin
                  r_d.prdata = {24'h0, cur_byte};
               end
            end
            LCP_ADDR_STAT: begin
               r_d.prdata = {r_q.fault_code[7:0], r_q.tx_len, r_q.tx_idx,
                  4'h0, r_q.bad, r_q.ovr, (r_q.st == LCP_EXEC),
                  (r_q.st == LCP_SEND)};
            end
            LCP_ADDR_MON: r_d.prdata = r_q.entry_total;
            default: r_d.pslverr = 1'b1; // unmapped
         endcase
      end
      // completing edge: writes and reply pops
      if (done && pwrite) begin
         case (paddr)
            LCP_ADDR_CTRL: begin
               if (pwdata[LCP_CTRL_CLR_OVR]) begin
                  r_d.ovr = 1'b0;
               end
               if (pwdata[LCP_CTRL_CLR_BAD]) begin
                  r_d.bad = 1'b0;
               end
               if (pwdata[LCP_CTRL_ABORT]) begin
                  r_d.st = LCP_RECV;
                  r_d.rx_cnt = 16'h0;
                  r_d.tx_idx = 8'h0;
               end
            end
            LCP_ADDR_MON: r_d.entry_total = pwdata;
            LCP_ADDR_CMD: begin
               if (r_q.st != LCP_RECV) begin
                  r_d.ovr = 1'b1; // byte dropped while busy
               end else if (r_q.rx_cnt == 16'h0 && pwdata[7:0] != LCP_LEAD) begin
                  r_d.bad = 1'b1; // resync on lead byte [R1]
               end else begin
                  if (r_q.rx_cnt < LCP_BUF_LEN) begin
                     r_d.rx[r_q.rx_cnt[4:0]] = pwdata[7:0];
                  end
                  r_d.rx_cnt = cnt_nx;
                  // header complete and length reached [R4]
                  if (cnt_nx >= LCP_HDR_LEN && cnt_nx >= pkt_len) begin
                     r_d.st = LCP_EXEC;
                  end
               end
            end
            default: ;
         endcase
      end else if (done && paddr == LCP_ADDR_RSP && r_q.st == LCP_SEND) begin
         r_d.tx_idx = r_q.tx_idx + 8'h01;
         if (r_d.tx_idx == r_q.tx_len) begin
            r_d.st = LCP_RECV;
            r_d.tx_idx = 8'h0;
         end
      end
      // execute the stored command
      if (r_q.st == LCP_EXEC) begin
         r_d.rx_cnt = 16'h0;
         r_d.tx_idx = 8'h0;
         r_d.fault_code = LCP_FLT_NONE;
         r_d.fault_text = 8'h00;
         if (r_q.rx[4] != LCP_OWN_NODE || r_q.rx[5] != LCP_LIN_IF) begin
            r_d.fault_code = LCP_FLT_ADDR; // [R6]
            r_d.fault_text = LCP_TXT_ADDR;
         end else if (r_q.rx[8] != LCP_TYPE_CMD) begin
            r_d.fault_code = LCP_FLT_TYPE; // [R20]
            r_d.fault_text = LCP_TXT_TYPE;
         end else if (r_q.rx[11] == LCP_CMD_FRD) begin
            if (pkt_len != LCP_FRD_LEN) begin
               r_d.fault_code = LCP_FLT_LEN; // [R5]
               r_d.fault_text = LCP_TXT_LEN;
            end
         end else if (r_q.rx[11] == LCP_CMD_MON) begin
            if (pkt_len != LCP_HDR_LEN) begin
               r_d.fault_code = LCP_FLT_LEN; // [R18]
               r_d.fault_text = LCP_TXT_LEN;
            end
         end else begin
            r_d.fault_code = LCP_FLT_CMD;
            r_d.fault_text = LCP_TXT_CMD;
         end
         // fault verdict taken inside this process, no loop through a net
         ok = (r_d.fault_code == LCP_FLT_NONE); // [R12]
         // frame response definition takes effect
         if (ok && r_q.rx[11] == LCP_CMD_FRD) begin
            r_d.lin.id = r_q.rx[12]; // [R14]
            r_d.lin.out_en = (r_q.rx[13] == LCP_MODE_OUT); // [R14]
            r_d.lin.staging_select = r_q.rx[14];
            r_d.lin.stage_en = (r_q.rx[14] != 8'h00); // [R15]
            r_d.lin.repeat_total = r_q.rx[15]; // [R16]
            r_d.lin.dlc = (r_q.rx[16] > 8'h08) ? 4'h8 : r_q.rx[16][3:0];
            for (int i = 0; i < 8; i++) begin
               // slots beyond dlc read as zero [R17]
               r_d.lin.data[i] = (i < r_q.rx[16]) ? r_q.rx[20 + i] : 8'h00;
            end
            r_d.lin_def = 1'b1;
         end
         // addressing swapped, echo tag and code repeated
         r_d.rsp_node = r_q.rx[6]; // [R8]
         r_d.rsp_ch = r_q.rx[7]; // [R8]
         r_d.echo_tag = r_q.rx[9]; // [R9]
         r_d.rsp_cmd = r_q.rx[11]; // [R11]
         r_d.st = LCP_RECV;
         if (ok && r_q.rx[11] == LCP_CMD_MON) begin
            r_d.rsp_type = LCP_TYPE_RSP; // [R19]
            r_d.tx_len = LCP_RSP_LEN;
            r_d.st = LCP_SEND;
         end else if (r_q.rx[1][0] || (r_q.rx[1][1] && !ok)) begin
            r_d.rsp_type = LCP_TYPE_ACK; // [R2] [R3]
            r_d.tx_len = ok ? LCP_ACK_OK_LEN : LCP_ACK_ERR_LEN; // [R13]
            r_d.st = LCP_SEND;
         end
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // outputs straight from flops
   assign prdata = r_q.prdata;
   assign pready = r_q.pready;
   assign pslverr = r_q.pslverr;
   assign lin_resp = r_q.lin;
   assign lin_define = r_q.lin_def;
endmodule

//--- lcp_checker.sv
// checker: port assertions of the packet handler
`timescale 1ns/10ps
module lcp_checker
   import lcp_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // lin response
   input wire lcp_pkg::lcp_lin_resp_t lin_resp,
   input wire logic lin_define
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // setup cycle, then first access cycle
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_first;
      s_setup ##1 (psel && penable);
   endsequence
   chk_ready_timing: assert property (s_first |=> pready) else $error("pready late");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   chk_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
   chk_err_qual: assert property (pslverr |-> pready) else $error("pslverr alone");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
   chk_define_pulse: assert property (lin_define |=> !lin_define) else $error("define long");
   chk_resp_hold: assert property (!lin_define |-> $stable(lin_resp)) else $error("resp moved");
   chk_stage_flag: assert property (lin_define |->
      lin_resp.stage_en == (lin_resp.staging_select != 8'h00)) else $error("stage flag");
   chk_dlc_clamp: assert property (lin_define |-> lin_resp.dlc <= 4'h8) else $error("dlc");
endmodule
bind lcp_handler lcp_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .lin_resp, .lin_define);

//--- lcp_host.sv
// host model: apb master that writes command packets
`timescale 1ns/10ps
module lcp_host
   import lcp_pkg::*;
(
   input wire logic pclk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [11:0] paddr = 12'h000,
   output logic [31:0] pwdata = 32'h0
);
   logic hang = 1'b0;
   logic [31:0] rdat;
   logic serr;
   // one transfer; pready, prdata and pslverr taken at the rising edge that samples pready
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // request held until pready is seen high at a rising edge
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      hang = hang | (n >= 50);
      rdat = prdata;
      serr = pslverr;
      // released at that same edge
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // command packet, one byte per write
   task automatic cmd(input logic [7:0] fl, cd, tg, ifn);
      logic [7:0] p[$];
      p = '{LCP_LEAD, fl, 8'h0c, 8'h00, LCP_OWN_NODE, ifn, 8'h00, 8'h00,
         LCP_TYPE_CMD, tg, 8'h00, cd};
      if (cd == LCP_CMD_FRD) begin
         p[2] = 8'h1c;
         p = {p, 8'h12, LCP_MODE_OUT, 8'h00, 8'h03, 8'h06, 8'h00, 8'h00, 8'h00};
         p = {p, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88};
      end
      foreach (p[i]) xfer(1'b1, LCP_ADDR_CMD, {24'h0, p[i]});
   endtask
endmodule

//--- tb.sv
// testbench: packet handler against a queue reference
`timescale 1ns/10ps
module tb;
   import lcp_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, lin_define;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, m;
   lcp_lin_resp_t lin_resp;
   int miscompares = 0;
   int checks_done = 0;
   logic [7:0] lfsr_q = 8'h4d;
   logic [7:0] t;
   logic [7:0] q[$];
   always #12.5 pclk = ~pclk;
   lcp_host host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
   lcp_handler dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .lin_resp, .lin_define);
   function automatic logic [7:0] rnd();
      lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      return lfsr_q;
   endfunction
   task automatic complete_run();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic stop_if(input logic c);
      if (c) begin
         miscompares++;
         complete_run();
      end
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      host.xfer(w, a, d);
      stop_if(host.hang);
   endtask
   // reference reply: header, payload, patched length
   task automatic expect_rsp(input logic [7:0] ty, cd, input logic [31:0] v, input logic [7:0] tx);
      q = '{LCP_LEAD, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, LCP_OWN_NODE, LCP_LIN_IF, ty, t, 8'h00, cd};
      for (int i = 0; i < 4; i++) q.push_back(v[8*i +: 8]);
      if (ty == LCP_TYPE_ACK && v != 0) q.push_back(tx);
      if (ty == LCP_TYPE_ACK) q.push_back(8'h00);
      q[2] = 8'(q.size());
   endtask
   // wait for a reply and read it byte by byte
   task automatic drain();
      int n;
      n = 0;
      do begin
         acc(1'b0, LCP_ADDR_STAT, 32'h0);
         n++;
      end while (host.rdat[0] !== 1'b1 && n < 20);
      stop_if(n >= 20);
      foreach (q[i]) begin
         acc(1'b0, LCP_ADDR_RSP, 32'h0);
         chk(host.rdat[7:0], q[i]);
      end
      acc(1'b0, LCP_ADDR_STAT, 32'h0);
      chk(host.rdat[0], 1'b0);
   endtask
   task automatic quiet();
      repeat (4) @(posedge pclk);
      acc(1'b0, LCP_ADDR_STAT, 32'h0);
      chk(host.rdat[0], 1'b0);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t = rnd();
      host.cmd(8'h01, LCP_CMD_FRD, t, LCP_LIN_IF);
      expect_rsp(LCP_TYPE_ACK, LCP_CMD_FRD, LCP_FLT_NONE, 8'h00);
      drain();
      chk({lin_resp.id, 7'h0, lin_resp.out_en, lin_resp.repeat_total, 4'h0, lin_resp.dlc},
         32'h12010306);
      chk({lin_resp.staging_select, 7'h0, lin_resp.stage_en, lin_resp.data[7:6]}, 0);
      chk(lin_resp.data[3:0], 32'h44332211);
      $display("frame definition test done");
      m = {rnd(), rnd(), rnd(), rnd()};
      t = rnd();
      acc(1'b1, LCP_ADDR_MON, m);
      host.cmd(8'h02, LCP_CMD_MON, t, LCP_LIN_IF);
      expect_rsp(LCP_TYPE_RSP, LCP_CMD_MON, m, 8'h00);
      drain();
      host.cmd(8'h02, LCP_CMD_FRD, t, LCP_LIN_IF);
      quiet();
      $display("monitor and silent test done");
      host.cmd(8'h02, LCP_CMD_FRD, t, 8'h01);
      expect_rsp(LCP_TYPE_ACK, LCP_CMD_FRD, LCP_FLT_ADDR, LCP_TXT_ADDR);
      drain();
      host.cmd(8'h00, LCP_CMD_FRD, t, 8'h01);
      quiet();
      $display("fault ack test done");
      acc(1'b1, LCP_ADDR_CMD, 32'h24);
      acc(1'b0, LCP_ADDR_STAT, 32'h0);
      chk(host.rdat[3], 1'b1);
      acc(1'b1, LCP_ADDR_CTRL, 32'h2);
      acc(1'b0, LCP_ADDR_STAT, 32'h0);
      chk(host.rdat[3], 1'b0);
      acc(1'b0, 12'h0ff, 32'h0);
      chk(host.serr, 1'b1);
      $display("lead byte and unmapped test done");
      complete_run();
   end
endmodule
